// ---- tb.sv ----
// Self-checking bench: AXI4-Lite register access and serial reception.
// Assumes ubr_top and the remote transmitter model ubr_rx_source.
`timescale 1ns/1ps
`include "ubr_cfg.svh"

module tb;
  logic        aclk;
  logic        aresetn;
  logic [11:0] awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [11:0] araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        rx_pin;
  logic        rx_irq;
  int          error_cnt;
  int          checks;

  localparam logic [1:0] ok  = `UBR_RESP_OKAY;
  localparam logic [1:0] dec = `UBR_RESP_DECERR;
  localparam logic [9:0] rxs = `UBR_IDX_RXSTAT;
  localparam logic [9:0] pfl = `UBR_IDX_PFLAGS;
  localparam logic [9:0] txs = `UBR_IDX_TXSTAT;
  localparam logic [9:0] bau = `UBR_IDX_BAUD;
  localparam logic [9:0] pen = `UBR_IDX_PENABLE;

  logic [9:0] idx_t [8] = '{`UBR_IDX_INTCTL, pfl, rxs, `UBR_IDX_RXDATA, pen, txs, bau, 10'h3ff};
  logic [7:0] rst_t [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
  logic [7:0] ff_t  [8] = '{8'hc0, 8'h00, 8'hf0, 8'h00, 8'h20, 8'h16, 8'hff, 8'h00};
  logic [7:0] tx_t  [4] = '{8'h04, 8'h00, 8'h04, 8'h00};
  logic [7:0] bd_t  [4] = '{8'h00, 8'h00, 8'h02, 8'h01};
  int         bc_t  [4] = '{16, 64, 48, 128};
  logic [7:0] dat_t [4] = '{8'ha5, 8'h3c, 8'h81, 8'h5a};

  ubr_top dut (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (awaddr),
    .s_axi_awvalid (awvalid),
    .s_axi_awready (awready),
    .s_axi_wdata   (wdata),
    .s_axi_wstrb   (4'hf),
    .s_axi_wvalid  (wvalid),
    .s_axi_wready  (wready),
    .s_axi_bresp   (bresp),
    .s_axi_bvalid  (bvalid),
    .s_axi_bready  (bready),
    .s_axi_araddr  (araddr),
    .s_axi_arvalid (arvalid),
    .s_axi_arready (arready),
    .s_axi_rdata   (rdata),
    .s_axi_rresp   (rresp),
    .s_axi_rvalid  (rvalid),
    .s_axi_rready  (rready),
    .rx_pin        (rx_pin),
    .rx_irq        (rx_irq)
  );

  ubr_rx_source src (
    .aclk   (aclk),
    .rx_pin (rx_pin)
  );

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t resp got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 1'b0;
    chk_resp(bresp, er);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [7:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk_data(rdata, {24'h0, e});
    chk_resp(rresp, er);
  endtask

  // One character in, then flag, status, data and flag clear
  task automatic rx_chk(input logic [8:0] d, input int nb, input int bc, input logic stop,
                        input logic [7:0] st, input logic irq);
    src.send(d, nb, bc, stop);
    chk_data({31'h0, rx_irq}, {31'h0, irq});
    rd(pfl, 8'h20, ok);
    rd(rxs, st, ok);
    rd(`UBR_IDX_RXDATA, d[7:0], ok);
    rd(pfl, 8'h00, ok);
  endtask

  task automatic results;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge aclk);
    error_cnt++;
    results();
  end

  initial begin
    aresetn = 1'b0;
    awaddr = 12'h000;
    awvalid = 1'b0;
    wdata = 32'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 12'h000;
    arvalid = 1'b0;
    rready = 1'b0;
    error_cnt = 0;
    checks = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++) rd(idx_t[i], rst_t[i], (i == 7) ? dec : ok);
    for (int i = 0; i < 8; i++) wr(idx_t[i], 8'hff, (i == 7) ? dec : ok);
    for (int i = 0; i < 8; i++) rd(idx_t[i], ff_t[i], (i == 7) ? dec : ok);
    wr(`UBR_IDX_INTCTL, 8'hc0, ok);
    wr(pen, 8'h20, ok);
    wr(rxs, 8'h90, ok);
    for (int i = 0; i < 4; i++) begin
      wr(txs, tx_t[i], ok);
      wr(bau, bd_t[i], ok);
      rx_chk({1'b0, dat_t[i]}, 8, bc_t[i], 1'b1, 8'h90, 1'b1);
    end
    wr(txs, 8'h04, ok);
    wr(bau, 8'h00, ok);
    wr(rxs, 8'hd0, ok);
    rx_chk(9'h13c, 9, 16, 1'b1, 8'hd1, 1'b1);
    rx_chk(9'h0c3, 9, 16, 1'b1, 8'hd0, 1'b1);
    wr(rxs, 8'h90, ok);
    rx_chk(9'h055, 8, 16, 1'b0, 8'h94, 1'b1);
    rx_chk(9'h0aa, 8, 16, 1'b1, 8'h90, 1'b1);
    wr(pen, 8'h00, ok);
    rx_chk(9'h033, 8, 16, 1'b1, 8'h90, 1'b0);
    src.send(9'h011, 8, 16, 1'b1);
    src.send(9'h022, 8, 16, 1'b1);
    rd(rxs, 8'h92, ok);
    rd(`UBR_IDX_RXDATA, 8'h11, ok);
    src.send(9'h044, 8, 16, 1'b1);
    rd(pfl, 8'h00, ok);
    wr(rxs, 8'h80, ok);
    rd(rxs, 8'h80, ok);
    src.send(9'h077, 8, 16, 1'b1);
    rd(pfl, 8'h00, ok);
    wr(rxs, 8'h90, ok);
    rx_chk(9'h066, 8, 16, 1'b1, 8'h90, 1'b0);
    results();
  end
endmodule

// ---- ubr_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the serial receiver.
// Assumes a 32-bit AXI4-Lite bus; byte address is four times the register index.
`ifndef UBR_CFG_SVH
`define UBR_CFG_SVH

// Register indices
`define UBR_IDX_INTCTL   10'h00b
`define UBR_IDX_PFLAGS   10'h00c
`define UBR_IDX_RXSTAT   10'h018
`define UBR_IDX_RXDATA   10'h01a
`define UBR_IDX_PENABLE  10'h08c
`define UBR_IDX_TXSTAT   10'h098
`define UBR_IDX_BAUD     10'h099

// Field positions
`define UBR_GLOBAL_IE_BIT  7
`define UBR_PERIPH_IE_BIT  6
`define UBR_RX_DONE_BIT    5
`define UBR_RX_IE_BIT      5
`define UBR_PORT_EN_BIT    7
`define UBR_NINE_BIT       6
`define UBR_SINGLE_RX_BIT  5
`define UBR_CONT_RX_BIT    4
`define UBR_FRAMING_BIT    2
`define UBR_OVERRUN_BIT    1
`define UBR_NINTH_BIT      0
`define UBR_SYNC_BIT       4
`define UBR_FAST_RATE_BIT  2
`define UBR_TX_EMPTY_BIT   1

// Reset values
`define UBR_TXSTAT_RST   8'h02
`define UBR_BAUD_RST     8'h00

// Generator ticks per bit for each formula
`define UBR_PPB_LOW      7'h40
`define UBR_PPB_HIGH     7'h10
`define UBR_PPB_SYNC     7'h04

// Bus answers
`define UBR_RESP_OKAY    2'h0
`define UBR_RESP_DECERR  2'h3

`endif

// ---- ubr_pkg.sv ----
// Types shared by the serial receiver.
// Assumes ubr_cfg.svh holds the numbers.
package ubr_pkg;
  typedef enum logic [1:0] {
    UBR_IDLE  = 2'b00,
    UBR_START = 2'b01,
    UBR_DATA  = 2'b10,
    UBR_STOP  = 2'b11
  } ubr_state_e;
endpackage

// ---- ubr_rx_source.sv ----
// Remote asynchronous transmitter model on the receive line.
// Assumes the bench calls send; the line idles high between frames.
`timescale 1ns/1ps

module ubr_rx_source (
  // Clock
  input  wire logic aclk,
  // Serial line
  output logic      rx_pin
);
  initial rx_pin = 1'b1;

  // One frame, each bit held for bc clocks, changed just after an edge
  task automatic send(input logic [8:0] d, input int nb, input int bc, input logic stop);
    logic [10:0] fr;
    fr = 11'h7ff;
    fr[0] = 1'b0;
    for (int i = 0; i < nb; i++) fr[i+1] = d[i];
    fr[nb+1] = stop;
    @(posedge aclk);
    for (int i = 0; i < nb + 2; i++) begin
      rx_pin <= fr[i];
      repeat (bc) @(posedge aclk);
    end
    rx_pin <= 1'b1;
  endtask
endmodule

// ---- ubr_top.sv ----
// Baud generator and asynchronous receive path with AXI4-Lite registers.
// Assumes rx_pin is already synchronous to aclk and idles high.
`timescale 1ns/1ps
`include "ubr_cfg.svh"

module ubr_top (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Serial line and interrupt request
  input  wire logic        rx_pin,
  output logic             rx_irq
);

  logic [9:0]  aw_idx_reg;
  logic        aw_held_reg;
  logic [31:0] wdata_reg;
  logic        w_held_reg;
  logic        do_wr;
  logic        wr_lane;
  logic        div_wr;
  logic        rd_fire;
  logic [1:0]  intctl_reg;
  logic        rx_irq_en_reg;
  logic [3:0]  rxctl_reg;
  logic [1:0]  txctl_reg;
  logic [7:0]  div_reg;
  logic [7:0]  rate_cnt_reg;
  logic        rate_tick;
  logic        rx_done_reg;
  logic        overrun_reg;
  logic        framing_reg;
  logic [8:0]  wr_look;
  logic [8:0]  rd_look;
  localparam logic [7:0] tx_rst = `UBR_TXSTAT_RST;
  logic        ninth_reg;
  logic [7:0]  rxbuf_reg;
  ubr_pkg::ubr_state_e state_reg;
  logic [5:0]  phase_reg;
  logic [3:0]  bcnt_reg;
  logic [8:0]  shift_reg;
  logic        v0_reg;
  logic        v1_reg;
  logic        done_reg;
  logic        stop_reg;
  logic [6:0]  ppb;
  logic [5:0]  mid;
  logic [3:0]  nbits;
  logic        rx_en;
  logic        bitv;

  wire port_en    = rxctl_reg[3];
  wire nine_bit   = rxctl_reg[2];
  wire cont_rx_en = rxctl_reg[0];
  wire sync       = txctl_reg[1];
  wire fast_rate  = txctl_reg[0];

  // Bit value of the middle three samples
  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction

  // Register read mux; top bit flags a mapped index
  function automatic logic [8:0] reg_read(input logic [9:0] idx);
    logic [7:0] d;
    logic       hit;
    d   = 8'h00;
    hit = 1'b1;
    case (idx)
      `UBR_IDX_INTCTL:  d = {intctl_reg, 6'h00};
      `UBR_IDX_PFLAGS:  d = {2'h0, rx_done_reg, 5'h00};
      `UBR_IDX_RXSTAT:  d = {rxctl_reg, 1'b0, framing_reg, overrun_reg, ninth_reg};
      `UBR_IDX_RXDATA:  d = rxbuf_reg;
      `UBR_IDX_PENABLE: d = {2'h0, rx_irq_en_reg, 5'h00};
      `UBR_IDX_TXSTAT:  d = {3'h0, txctl_reg[1], 1'b0, txctl_reg[0], 2'h2};
      `UBR_IDX_BAUD:    d = div_reg;
      default:          hit = 1'b0;
    endcase
    reg_read = {hit, d};
  endfunction

  assign wr_look = reg_read(aw_idx_reg);
  assign rd_look = reg_read(s_axi_araddr[11:2]);

  // Write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_held_reg   <= 1'b0;
      aw_idx_reg    <= 10'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_idx_reg    <= s_axi_awaddr[11:2];
      aw_held_reg   <= 1'b1;
      s_axi_awready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_held_reg   <= 1'b0;
      s_axi_awready <= 1'b1;
    end else if (!aw_held_reg) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_held_reg   <= 1'b0;
      wdata_reg    <= 32'h00000000;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wdata_reg    <= s_axi_wdata;
      w_held_reg   <= 1'b1;
      s_axi_wready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_held_reg   <= 1'b0;
      s_axi_wready <= 1'b1;
    end else if (!w_held_reg) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Low byte lane is captured with the data
  logic wstrb0_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstrb0_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wstrb0_reg <= s_axi_wstrb[0];
    end
  end

  assign do_wr   = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_lane = do_wr && wstrb0_reg;
  assign div_wr  = wr_lane && (aw_idx_reg == `UBR_IDX_BAUD);

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `UBR_RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_look[8] ? `UBR_RESP_OKAY : `UBR_RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `UBR_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h000000, rd_look[7:0]};
      s_axi_rresp   <= rd_look[8] ? `UBR_RESP_OKAY : `UBR_RESP_DECERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // Software-written control fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      intctl_reg <= 2'h0;
      rx_irq_en_reg <= 1'b0;
      rxctl_reg  <= 4'h0;
      txctl_reg  <= {tx_rst[`UBR_SYNC_BIT], tx_rst[`UBR_FAST_RATE_BIT]};
      div_reg    <= `UBR_BAUD_RST;
    end else if (wr_lane) begin
      case (aw_idx_reg)
        `UBR_IDX_INTCTL:  intctl_reg <= {wdata_reg[`UBR_GLOBAL_IE_BIT], wdata_reg[`UBR_PERIPH_IE_BIT]};
        `UBR_IDX_PENABLE: rx_irq_en_reg <= wdata_reg[`UBR_RX_IE_BIT];
        `UBR_IDX_RXSTAT:  rxctl_reg  <= wdata_reg[`UBR_PORT_EN_BIT:`UBR_CONT_RX_BIT];
        `UBR_IDX_TXSTAT:  txctl_reg  <= {wdata_reg[`UBR_SYNC_BIT], wdata_reg[`UBR_FAST_RATE_BIT]};
        `UBR_IDX_BAUD:    div_reg    <= wdata_reg[7:0];
        default:          ;
      endcase
    end
  end

  // Free-running generator, one tick every divisor plus one clocks
  assign rate_tick = (rate_cnt_reg == 8'h00) && !div_wr;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_cnt_reg <= 8'h00;
    end else if (div_wr) begin
      rate_cnt_reg <= 8'h00;
    end else if (rate_cnt_reg == 8'h00) begin
      rate_cnt_reg <= div_reg;
    end else begin
      rate_cnt_reg <= rate_cnt_reg - 8'h01;
    end
  end

  // The formula selects the ticks per bit
  always_comb begin
    if (sync) begin
      ppb = `UBR_PPB_SYNC;
    end else if (fast_rate) begin
      ppb = `UBR_PPB_HIGH;
    end else begin
      ppb = `UBR_PPB_LOW;
    end
  end

  assign mid   = ppb[6:1];
  assign nbits = nine_bit ? 4'h9 : 4'h8;
  assign rx_en = port_en && cont_rx_en && !sync && !overrun_reg;
  assign bitv  = maj3(v0_reg, v1_reg, rx_pin);

  // Character framing
  always_ff @(posedge aclk) begin
    if (!aresetn || !rx_en) begin
      state_reg <= ubr_pkg::UBR_IDLE;
      phase_reg <= 6'h00;
      bcnt_reg  <= 4'h0;
      shift_reg <= 9'h000;
      v0_reg    <= 1'b1;
      v1_reg    <= 1'b1;
      done_reg  <= 1'b0;
      stop_reg  <= 1'b1;
    end else begin
      done_reg <= 1'b0;
      if (rate_tick) begin
        if (state_reg == ubr_pkg::UBR_IDLE) begin
          phase_reg <= 6'h00;
          if (!rx_pin) begin
            state_reg <= ubr_pkg::UBR_START;
          end
        end else begin
          phase_reg <= (phase_reg == 6'(ppb - 7'h01)) ? 6'h00 : phase_reg + 6'h01;
          if (phase_reg == mid - 6'h01) begin
            v0_reg <= rx_pin;
          end
          if (phase_reg == mid) begin
            v1_reg <= rx_pin;
          end
          if (phase_reg == mid + 6'h01) begin
            unique case (state_reg)
              ubr_pkg::UBR_START: begin
                bcnt_reg  <= 4'h0;
                state_reg <= bitv ? ubr_pkg::UBR_IDLE : ubr_pkg::UBR_DATA;
              end
              ubr_pkg::UBR_DATA: begin
                shift_reg <= {bitv, shift_reg[8:1]};
                bcnt_reg  <= bcnt_reg + 4'h1;
                if (bcnt_reg == nbits - 4'h1) begin
                  state_reg <= ubr_pkg::UBR_STOP;
                end
              end
              ubr_pkg::UBR_STOP: begin
                done_reg  <= 1'b1;
                stop_reg  <= bitv;
                state_reg <= ubr_pkg::UBR_IDLE;
              end
              ubr_pkg::UBR_IDLE: ;
            endcase
          end
        end
      end
    end
  end

  // Receive buffer and status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_done_reg <= 1'b0;
      overrun_reg <= 1'b0;
      framing_reg <= 1'b0;
      ninth_reg   <= 1'b0;
      rxbuf_reg   <= 8'h00;
    end else begin
      if (done_reg && !rx_done_reg) begin
        rx_done_reg <= 1'b1;
        framing_reg <= !stop_reg;
        ninth_reg   <= nine_bit ? shift_reg[8] : 1'b0;
        rxbuf_reg   <= nine_bit ? shift_reg[7:0] : shift_reg[8:1];
      end else if (rd_fire && s_axi_araddr[11:2] == `UBR_IDX_RXDATA) begin
        rx_done_reg <= 1'b0;
      end
      if (!cont_rx_en) begin
        overrun_reg <= 1'b0;
        framing_reg <= 1'b0;
      end else if (done_reg && rx_done_reg) begin
        overrun_reg <= 1'b1;
      end
    end
  end

  // Interrupt request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_irq <= 1'b0;
    end else begin
      rx_irq <= rx_done_reg && rx_irq_en_reg;
    end
  end

  a_div_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    div_wr |=> rate_cnt_reg == 8'h00 ##1 rate_cnt_reg == $past(div_reg))
    else $error("divisor write did not clear generator");

  a_tick_reload: assert property (@(posedge aclk) disable iff (!aresetn)
    rate_tick |=> rate_cnt_reg == $past(div_reg))
    else $error("generator did not reload divisor");

  a_rate_low: assert property (@(posedge aclk) disable iff (!aresetn)
    (!sync && !fast_rate) |-> ppb == 7'd64)
    else $error("low speed ratio wrong");

  a_rate_high: assert property (@(posedge aclk) disable iff (!aresetn)
    (!sync && fast_rate) |-> ppb == 7'd16)
    else $error("high speed ratio wrong");

  a_rate_sync: assert property (@(posedge aclk) disable iff (!aresetn)
    sync |-> ppb == 7'd4)
    else $error("clocked mode ratio wrong");

  a_rx_halt: assert property (@(posedge aclk) disable iff (!aresetn)
    !cont_rx_en |=> state_reg == ubr_pkg::UBR_IDLE && !done_reg)
    else $error("receiver ran while disabled");

  a_err_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    !cont_rx_en |=> !overrun_reg && !framing_reg)
    else $error("errors not cleared");

  a_done_irq: assert property (@(posedge aclk) disable iff (!aresetn)
    (done_reg && !rx_done_reg && rx_irq_en_reg) |=> rx_done_reg ##1 rx_irq)
    else $error("done flag or interrupt missing");

  a_overrun_set: assert property (@(posedge aclk) disable iff (!aresetn)
    (done_reg && rx_done_reg && cont_rx_en) |=> overrun_reg && $stable(rxbuf_reg))
    else $error("overrun not flagged");

  a_bit_count: assert property (@(posedge aclk) disable iff (!aresetn)
    done_reg |-> bcnt_reg == nbits)
    else $error("wrong data bit count");

  a_read_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");

endmodule
